// File: verilog/rst_seq_pkg.sv
// Constants and types shared by the panel reset sequencer
package rst_seq_pkg;
   // Clock and timing figures
   localparam int MCLK_MHZ = 125;
   localparam int REJECT_US = 5;
   localparam int FULL_US = 9;
   localparam int CMD_WAIT_MS = 5;
   localparam int SLP_WAIT_MS = 120;
   // Least filter time rounds up; it sits at the reject edge
   localparam int FILT_CYC = REJECT_US * MCLK_MHZ;
   localparam int CMD_WAIT_CYC = CMD_WAIT_MS * 1000 * MCLK_MHZ;
   localparam int SLP_WAIT_CYC = SLP_WAIT_MS * 1000 * MCLK_MHZ;
   // Pin-to-release latency of sync and filter, with a few cycles spare
   localparam int REL_LAT_CYC = FILT_CYC + 8;
   localparam int FILT_W = 11;
   localparam int TM_W = 24;
   // Stored settings: three id bytes then the common voltage byte
   localparam int NV_WORDS = 4;
   localparam int NV_AW = 2;
   localparam int LOAD_END = 4;
   // Stored contents; the values are arbitrary
   localparam logic [7:0] NV_ID0 = 8'h11;
   localparam logic [7:0] NV_ID1 = 8'h22;
   localparam logic [7:0] NV_ID2 = 8'h33;
   localparam logic [7:0] NV_COMMON_VOLTAGE_SETTING = 8'h40;
   localparam logic [7:0] SET_RST = 8'h00;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_WAIT = 4'b1000
   } seq_state_e;

   typedef struct packed {
      logic [7:0] id0;
      logic [7:0] id1;
      logic [7:0] id2;
      logic [7:0] common_voltage_setting;
   } panel_settings_s;
endpackage

// File: verilog/nonvolatile_store.sv
// Small read-only settings store with registered read data
`timescale 1ns/1ns
module nonvolatile_store
   import rst_seq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [NV_AW-1:0] addr,
   output logic [7:0] rdata
);
   logic [7:0] word_sel;

   // Word select, id bytes first
   assign word_sel = (addr == 2'h0) ? NV_ID0 :
                     (addr == 2'h1) ? NV_ID1 :
                     (addr == 2'h2) ? NV_ID2 : NV_COMMON_VOLTAGE_SETTING;

   // One cycle read latency
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= SET_RST;
      end else begin
         rdata <= word_sel;
      end
   end
endmodule // nonvolatile_store

// File: verilog/panel_hw_reset_sequencer.sv
// Contract
// - Reset lows under 5 us are ignored and lows over 9 us reset fully.
// - Lows between 5 and 9 us may start a reset with no promise either way.
// - Short highs inside a valid reset low are filtered the same way.
// - Every release reloads id bytes and voltage setting from the store.
// - Cancel ends within 5 ms from sleep-in or 120 ms from sleep-out.
// - The display is blank while resetting, then default state returns.
`timescale 1ns/1ns
module panel_hw_reset_sequencer
   import rst_seq_pkg::*;
#(
   // Counts run from filtered release, so the filter latency comes off
   parameter int CMD_CYC = CMD_WAIT_CYC - REL_LAT_CYC,
   parameter int SLP_CYC = SLP_WAIT_CYC - REL_LAT_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic panel_reset_low,
   input wire logic sleep_out_mode,
   output logic core_reset,
   output logic display_blank,
   output logic hw_default,
   output logic cmd_ready,
   output logic sleep_out_ready,
   output panel_settings_s settings
);
   localparam logic [TM_W-1:0] CMD_LIM = TM_W'(CMD_CYC - 1);
   localparam logic [TM_W-1:0] SLP_LIM = TM_W'(SLP_CYC - 1);
   localparam logic [FILT_W-1:0] FILT_LIM = FILT_W'(FILT_CYC - 1);

   logic pin_m_r, pin_s_r;
   logic filt_r, filt_nxt;
   logic [FILT_W-1:0] cnt_r, cnt_nxt;
   seq_state_e state_r, state_nxt;
   logic slp_out_r;
   logic [2:0] ld_idx_r;
   logic [TM_W-1:0] tm_r, tm_nxt;
   logic [7:0] nv_data;
   logic [7:0] set_r [NV_WORDS];
   logic hw_default_r;
   logic pin_low, differ, flip, released, ld_last, cancel_done;
   logic [TM_W-1:0] cancel_lim;

   // Two-flop synchroniser on the pin, low means reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_m_r <= 1'b1;
         pin_s_r <= 1'b1;
      end else begin
         pin_m_r <= panel_reset_low;
         pin_s_r <= pin_m_r;
      end
   end

   // One filter serves both edges so spikes either way are eaten
   assign pin_low = ~pin_s_r;
   assign differ = pin_low != filt_r;
   assign flip = differ && (cnt_r == FILT_LIM);
   assign filt_nxt = flip ? pin_low : filt_r;
   assign cnt_nxt = (differ && !flip) ? cnt_r + FILT_W'(1) : '0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         filt_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         filt_r <= filt_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Sequencing decodes
   assign released = (state_r == ST_HOLD) && !filt_r;
   assign ld_last = (state_r == ST_LOAD) && (ld_idx_r == 3'(LOAD_END));
   // limit chosen by mode at reset
   assign cancel_lim = slp_out_r ? SLP_LIM : CMD_LIM;
   assign cancel_done = (state_r == ST_WAIT) && (tm_r >= cancel_lim);

   // Main state machine; a new reset low always wins
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (filt_r) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!filt_r) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (filt_r) begin
               state_nxt = ST_HOLD;
            end else if (ld_last) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (filt_r) begin
               state_nxt = ST_HOLD;
            end else if (cancel_done) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_HOLD;
      endcase
   end

   // Release timer, saturates at the sleep-out wait
   assign tm_nxt = released ? '0 :
                   (tm_r < SLP_LIM) ? tm_r + TM_W'(1) : tm_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_HOLD;
         tm_r <= '0;
      end else begin
         state_r <= state_nxt;
         tm_r <= tm_nxt;
      end
   end

   // Sleep mode is caught as a reset begins from run, blank length follows it
   always_ff @(posedge mclk) begin
      if (rst) begin
         slp_out_r <= 1'b0;
      end else if ((state_r == ST_RUN) && filt_r) begin
         slp_out_r <= sleep_out_mode;
      end
   end

   // Load index: address k goes out, data k-1 comes back
   always_ff @(posedge mclk) begin
      if (rst) begin
         ld_idx_r <= '0;
      end else if (state_r == ST_LOAD) begin
         ld_idx_r <= ld_idx_r + 3'h1;
      end else begin
         ld_idx_r <= '0;
      end
   end

   nonvolatile_store nonvolatile_store_inst (
      .mclk(mclk),
      .rst(rst),
      .addr(ld_idx_r[NV_AW-1:0]),
      .rdata(nv_data)
   );

   // Settings registers, one per stored word
   genvar gi;
   generate
      for (gi = 0; gi < NV_WORDS; gi++) begin : g_set
         always_ff @(posedge mclk) begin
            if (rst) begin
               set_r[gi] <= SET_RST;
            end else if ((state_r == ST_LOAD) &&
                         (ld_idx_r == 3'(gi + 1))) begin
               set_r[gi] <= nv_data;
            end
         end
      end
   endgenerate

   assign settings = {set_r[0], set_r[1], set_r[2], set_r[3]};

   always_ff @(posedge mclk) begin
      if (rst) begin
         hw_default_r <= 1'b0;
      end else begin
         hw_default_r <= cancel_done && !filt_r;
      end
   end

   assign hw_default = hw_default_r;
   assign core_reset = state_r == ST_HOLD;
   assign display_blank = state_r != ST_RUN;
   assign cmd_ready = !filt_r && (state_r != ST_HOLD) &&
                      (state_r != ST_LOAD) && (tm_r >= CMD_LIM);
   assign sleep_out_ready = cmd_ready && (tm_r >= SLP_LIM);

   // Checks on the sequence
   sequence load_entry_q;
      $rose(state_r == ST_LOAD);
   endsequence
   sequence load_run_q;
      (state_r == ST_LOAD)[*5] ##1 (state_r == ST_WAIT);
   endsequence

   glitch_reject_a: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(filt_r) |-> $past(cnt_r) == FILT_LIM)
      else $error("reset accepted before filter time");
   filter_bound_a: assert property (
      @(posedge mclk) disable iff (rst)
      cnt_r <= FILT_LIM)
      else $error("filter count overran");
   band_start_a: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(filt_r) |=> (state_r == ST_HOLD))
      else $error("accepted reset did not enter hold");
   spike_reject_a: assert property (
      @(posedge mclk) disable iff (rst)
      $fell(filt_r) |-> $past(cnt_r) == FILT_LIM && $past(pin_s_r))
      else $error("reset ended before stable high");
   load_release_a: assert property (
      @(posedge mclk) disable iff (rst)
      released |=> (state_r == ST_LOAD))
      else $error("release did not start reload");
   load_length_a: assert property (
      @(posedge mclk) disable iff (rst || filt_r)
      load_entry_q |-> load_run_q)
      else $error("reload did not take five cycles");
   cancel_limit_a: assert property (
      @(posedge mclk) disable iff (rst)
      (state_r == ST_WAIT) |-> tm_r <= cancel_lim)
      else $error("cancel ran past its limit");
   blank_hold_a: assert property (
      @(posedge mclk) disable iff (rst)
      filt_r |=> display_blank && !cmd_ready)
      else $error("display not blank in reset");
   default_pulse_a: assert property (
      @(posedge mclk) disable iff (rst)
      hw_default |-> (state_r == ST_RUN) && $past(state_r == ST_WAIT))
      else $error("default pulse out of place");
   cmd_gate_a: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(cmd_ready) |-> tm_r == CMD_LIM)
      else $error("commands opened too early");
   sleep_gate_a: assert property (
      @(posedge mclk) disable iff (rst)
      sleep_out_ready |-> tm_r == SLP_LIM)
      else $error("sleep-out opened too early");
endmodule // panel_hw_reset_sequencer

// File: dv/host_model.sv
// Host-side driver of the panel reset pin
`timescale 1ns/1ns
module host_model (
   input wire logic mclk,
   output logic panel_reset_low
);
   // Released pin idles high, the host keeps it driven
   initial begin
      panel_reset_low = 1'b1;
   end

   // level held for n cycles
   // Changes land on the falling edge, clear of the sync flops
   task automatic drive(input logic v, input int n);
      @(negedge mclk);
      panel_reset_low = v;
      repeat (n) @(negedge mclk);
   endtask
endmodule // host_model

// File: dv/panel_hw_reset_sequencer_tb_top.sv
// Self-checking bench for the panel reset sequencer
`timescale 1ns/1ns
module panel_hw_reset_sequencer_tb_top;
   import rst_seq_pkg::*;
   // Short cancel counts keep the run brief
   localparam int CMD = 40;
   localparam int SLP = 100;
   logic mclk, rst, sleep_out_mode, panel_reset_low;
   logic core_reset, display_blank, hw_default, cmd_ready, sleep_out_ready;
   panel_settings_s settings;
   int fails = 0;
   int n_checks = 0;
   int rises = 0;
   int falls = 0;
   int n, r, f;

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Edge counters show any filter slip between samples
   always @(posedge core_reset) rises++;
   always @(negedge core_reset) falls++;

   host_model host_model_inst (.mclk(mclk), .panel_reset_low(panel_reset_low));
   panel_hw_reset_sequencer #(.CMD_CYC(CMD), .SLP_CYC(SLP))
      panel_hw_reset_sequencer_inst (.mclk(mclk), .rst(rst),
      .panel_reset_low(panel_reset_low), .sleep_out_mode(sleep_out_mode),
      .core_reset(core_reset), .display_blank(display_blank),
      .hw_default(hw_default), .cmd_ready(cmd_ready),
      .sleep_out_ready(sleep_out_ready), .settings(settings));

   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   task automatic check_rng(input int got, input int lo, input int hi,
                            input string m);
      n_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("MISMATCH %0t %s got %0d", $time, m, got);
      end
   endtask

   task automatic check_set(input panel_settings_s got);
      n_checks++;
      if (got !== {NV_ID0, NV_ID1, NV_ID2, NV_COMMON_VOLTAGE_SETTING}) begin
         fails++;
         $display("MISMATCH %0t settings %h", $time, got);
      end
   endtask

   // Bounded wait for release, then time the cancel to its default pulse
   task automatic recover(input int lim);
      int k;
      k = 0;
      while (core_reset !== 1'b0 && k < 2000) begin
         @(negedge mclk);
         k++;
      end
      n = 0;
      while (hw_default !== 1'b1 && n < lim + 20) begin
         check_bit(display_blank, 1'b1, "not blank in cancel");
         @(negedge mclk);
         n++;
      end
      if (k == 2000 || n == lim + 20) begin
         check_bit(1'b0, 1'b1, "cancel wait timed out");
         test_done();
      end
      check_rng(n, lim - 1, lim + 8, "cancel time");
      check_bit(cmd_ready, 1'b1, "not ready after cancel");
      check_set(settings);
      @(negedge mclk);
      check_bit(hw_default, 1'b0, "default pulse too long");
      check_bit(display_blank, 1'b0, "blank after default");
   endtask

   task automatic t_glitch();
      r = rises;
      host_model_inst.drive(1'b0, 600);
      host_model_inst.drive(1'b1, 700);
      check_rng(rises - r, 0, 0, "short low reset");
   endtask

   task automatic t_long();
      host_model_inst.drive(1'b0, 1250);
      check_bit(core_reset, 1'b1, "long low ignored");
      check_bit(display_blank, 1'b1, "not blank in reset");
      host_model_inst.drive(1'b1, 0);
      recover(CMD);
   endtask

   task automatic t_spike();
      host_model_inst.drive(1'b0, 1250);
      f = falls;
      host_model_inst.drive(1'b1, 300);
      host_model_inst.drive(1'b0, 800);
      check_rng(falls - f, 0, 0, "spike ended reset");
      check_bit(core_reset, 1'b1, "reset dropped");
      host_model_inst.drive(1'b1, 0);
      recover(CMD);
   endtask

   // Mid band may go either way; only a working return is demanded
   task automatic t_band();
      host_model_inst.drive(1'b0, 700);
      host_model_inst.drive(1'b1, FILT_CYC + 10);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      check_bit(cmd_ready, 1'b1, "band pulse hung");
      check_set(settings);
      if (n == 3000) begin
         test_done();
      end
   endtask

   task automatic t_sleep_out();
      n = 0;
      while (sleep_out_ready !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check_bit(sleep_out_ready, 1'b1, "sleep-out never ready");
      if (n == 200) begin
         test_done();
      end
      sleep_out_mode = 1'b1;
      host_model_inst.drive(1'b0, 1250);
      host_model_inst.drive(1'b1, 0);
      recover(SLP);
      check_bit(sleep_out_ready, 1'b1, "sleep-out ready lost");
   endtask

   initial begin
      rst = 1'b1;
      sleep_out_mode = 1'b0;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      recover(CMD);
      t_glitch();
      t_long();
      t_spike();
      t_band();
      t_sleep_out();
      test_done();
   end
endmodule // panel_hw_reset_sequencer_tb_top
